// file: dv/gpcr_pads.sv
// Board-side model of one port's pads: external drivers, pulls, floating
`timescale 1ns/1ps
module gpcr_pads (
	// Clock
	input  wire logic                    clk,
	// Device side
	input  wire logic [7:0]              pad_out,
	input  wire logic [7:0]              pad_oe,
	input  wire gpcr_pkg::gpcr_pad_cfg_t pad_cfg,
	// Board side
	input  wire logic [7:0]              ext_val,
	input  wire logic [7:0]              ext_oe,
	output logic      [7:0]              pad_in
);
	logic [7:0] float_q = 8'h00;
	logic [7:0] idle;

	// A pin nobody drives and nothing pulls toggles every cycle, so a
	// stale level can never pass for real data
	always_ff @(posedge clk)
	begin
		float_q <= ~pad_in;
	end

	assign idle = pad_cfg.pull_up_select |
		(~pad_cfg.pull_down_select & float_q);
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val) |
		(~pad_oe & ~ext_oe & idle);
endmodule : gpcr_pads

// file: dv/test_gpcr_port.sv
// Self-checking bench: ports B and C on one register bus
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED at %0t: got %h want %h", $time, (g), (e)); end end
module test_gpcr_port;
	typedef struct packed {
		logic [11:0] o;
		logic [7:0]  w;
		logic [7:0]  e;
	} gpcr_row_t;

	localparam logic [31:0] B = 32'h4000_5000;
	localparam logic [31:0] C = 32'h4000_6000;

	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	gpcr_pkg::gpcr_bus_t     bus = '0;
	logic [31:0]             rdata_b;
	logic [31:0]             rdata_c;
	logic [31:0]             rdata;
	logic [7:0]              pad_in_b;
	logic [7:0]              pad_out_b;
	logic [7:0]              pad_oe_b;
	gpcr_pkg::gpcr_pad_cfg_t cfg_b;
	gpcr_pkg::gpcr_pad_cfg_t cfg_c;
	logic [7:0]              alt_out = 8'h00;
	logic [7:0]              alt_oe = 8'h00;
	logic [7:0]              alt_in_b;
	logic                    irq_b;
	logic [7:0]              ext_val = 8'h00;
	logic [7:0]              ext_oe = 8'h00;
	int                      checks = 0;
	int                      fails = 0;
	gpcr_row_t               rows [15] = '{
		'{gpcr_pkg::OFS_DIR,   8'h5A, 8'h5A},
		'{gpcr_pkg::OFS_ISNS,  8'h33, 8'h33},
		'{gpcr_pkg::OFS_IBE,   8'hC3, 8'hC3},
		'{gpcr_pkg::OFS_IEV,   8'h0F, 8'h0F},
		'{gpcr_pkg::OFS_IMSK,  8'h00, 8'h00},
		'{gpcr_pkg::OFS_DRV2,  8'h11, 8'h11},
		'{gpcr_pkg::OFS_DRV4,  8'h22, 8'h22},
		'{gpcr_pkg::OFS_DRV8,  8'h44, 8'h44},
		'{gpcr_pkg::OFS_ODR,   8'h01, 8'h01},
		'{gpcr_pkg::OFS_PUR,   8'h3C, 8'h3C},
		'{gpcr_pkg::OFS_PDR,   8'hC0, 8'hC0},
		'{gpcr_pkg::OFS_SLEW,  8'hA5, 8'hA5},
		'{gpcr_pkg::OFS_AFSEL, 8'h01, 8'h81},
		'{gpcr_pkg::OFS_CMT,   8'h00, 8'h7F},
		'{12'h600,             8'hFF, 8'h00}
	};

	assign rdata = rdata_b | rdata_c;
	always #25 clk = ~clk;

	gpcr_port #(.PORT_ID(3'h1), .PAD_MASK(8'hFF)) u_gpcr_port (
		.clk(clk), .rst(rst), .bus(bus), .bus_rdata(rdata_b),
		.pad_in(pad_in_b), .pad_out(pad_out_b), .pad_oe(pad_oe_b),
		.pad_cfg(cfg_b), .alt_out(alt_out), .alt_oe(alt_oe),
		.alt_in(alt_in_b), .port_irq(irq_b));
	// Pins 7:6 of port C have no pad
	gpcr_port #(.PORT_ID(3'h2), .PAD_MASK(8'h3F)) u_gpcr_port_c (
		.clk(clk), .rst(rst), .bus(bus), .bus_rdata(rdata_c),
		.pad_in(ext_val), .pad_out(), .pad_oe(), .pad_cfg(cfg_c),
		.alt_out(alt_out), .alt_oe(alt_oe), .alt_in(), .port_irq());
	gpcr_pads u_gpcr_pads (
		.clk(clk), .pad_out(pad_out_b), .pad_oe(pad_oe_b), .pad_cfg(cfg_b),
		.ext_val(ext_val), .ext_oe(ext_oe), .pad_in(pad_in_b));

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic wr32(input logic [31:0] b, input logic [11:0] o,
		input logic [31:0] d);
		@(posedge clk);
		bus.addr  <= {b[31:12], o};
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge clk);
		bus.wr    <= 1'b0;
	endtask : wr32

	task automatic wr(input logic [31:0] b, input logic [11:0] o,
		input logic [7:0] d);
		wr32(b, o, {24'h00_0000, d});
	endtask : wr

	task automatic rd(input logic [31:0] b, input logic [11:0] o,
		input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		bus.addr <= {b[31:12], o};
		bus.rd   <= 1'b1;
		@(posedge clk);
		bus.rd   <= 1'b0;
		@(negedge clk);
		`CHK({rdata[31:8], rdata[7:0] & m}, {24'h00_0000, e & m})
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// Pad sync plus sticky status settle well inside eight cycles
	task automatic irq_chk(input logic e);
		cyc(8);
		`CHK(irq_b, e)
	endtask : irq_chk

	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask : do_reset

	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	initial
	begin
		#2000000;
		fails++;
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		do_reset();
		foreach (rows[i])
		begin
			wr(B, rows[i].o, rows[i].w);
			rd(B, rows[i].o, rows[i].e, 8'hFF);
		end
		`CHK(cfg_b, 64'h013C_C011_2244_A580)
		rd(C, gpcr_pkg::OFS_DIR, 8'h00, 8'hFF);
		wr(C, gpcr_pkg::OFS_DIR, 8'h3F);
		rd(C, gpcr_pkg::OFS_DIR, 8'h3F, 8'hFF);
		rd(B, gpcr_pkg::OFS_DIR, 8'h5A, 8'hFF);

		// Second reset in mid-run, then reset state
		do_reset();
		`CHK(pad_oe_b, 8'h00)
		`CHK(cfg_b.pull_down_select, 8'h00)
		`CHK(cfg_b.pull_up_select, 8'h80)
		`CHK(cfg_b.digital_enable_reg, 8'h80)
		`CHK(cfg_c.pull_up_select, 8'h0F)
		`CHK(cfg_c.digital_enable_reg, 8'h0F)
		`CHK({irq_b, alt_in_b}, 9'h000)
		rd(B, gpcr_pkg::OFS_AFSEL, 8'h80, 8'hFF);
		rd(C, gpcr_pkg::OFS_AFSEL, 8'h0F, 8'hFF);
		rd(B, gpcr_pkg::OFS_CMT, 8'h7F, 8'hFF);
		rd(C, gpcr_pkg::OFS_CMT, 8'hF0, 8'h3F);
		wr(C, gpcr_pkg::OFS_PUR, 8'hFF);
		cyc(2);
		`CHK(cfg_c.pull_up_select, 8'h3F)

		// Push-pull, open-drain and input pins on port B
		wr(B, gpcr_pkg::OFS_DEN, 8'hFF);
		wr(B, gpcr_pkg::OFS_DIR, 8'h0F);
		wr(B, gpcr_pkg::OFS_DATA, 8'h05);
		ext_oe  <= 8'hF0;
		ext_val <= 8'hA0;
		cyc(3);
		`CHK({pad_oe_b, pad_out_b}, 16'h0F05)
		rd(B, gpcr_pkg::OFS_DATA, 8'hA5, 8'hFF);
		wr(B, gpcr_pkg::OFS_ODR, 8'h03);
		cyc(3);
		`CHK({pad_oe_b, pad_out_b}, 16'h0E04)
		wr(B, gpcr_pkg::OFS_DEN, 8'h0F);
		cyc(4);
		rd(B, gpcr_pkg::OFS_DATA, 8'h05, 8'hFF);

		// Peripheral takes pin 4; direction bit there stays 0
		wr(B, gpcr_pkg::OFS_DEN, 8'hFF);
		wr(B, gpcr_pkg::OFS_AFSEL, 8'h10);
		alt_out <= 8'h10;
		alt_oe  <= 8'h10;
		cyc(7);
		`CHK({pad_oe_b[4], pad_out_b[4]}, 2'h3)
		`CHK(alt_in_b, 8'h90)
		wr(B, gpcr_pkg::OFS_ODR, 8'h13);
		cyc(3);
		`CHK({pad_oe_b[4], pad_out_b[4]}, 2'h0)

		// Commit guard on the debug pins
		wr32(B, gpcr_pkg::OFS_LOCK, 32'h0000_C0DE);
		wr(B, gpcr_pkg::OFS_CMT, 8'hFF);
		rd(B, gpcr_pkg::OFS_CMT, 8'hFF, 8'hFF);
		wr(B, gpcr_pkg::OFS_AFSEL, 8'h00);
		rd(B, gpcr_pkg::OFS_AFSEL, 8'h00, 8'hFF);
		wr32(B, gpcr_pkg::OFS_LOCK, 32'h0000_0000);
		wr(B, gpcr_pkg::OFS_AFSEL, 8'hFF);
		rd(B, gpcr_pkg::OFS_AFSEL, 8'h7F, 8'hFF);
		wr32(C, gpcr_pkg::OFS_LOCK, 32'h0000_C0DE);
		wr(C, gpcr_pkg::OFS_CMT, 8'h00);
		rd(C, gpcr_pkg::OFS_CMT, 8'hF0, 8'h3F);

		// Pin 2 interrupt: rise, fall, both edges, level, mask, gate
		do_reset();
		@(posedge clk);
		alt_oe  <= 8'h00;
		ext_oe  <= 8'hFF;
		ext_val <= 8'h00;
		wr(B, gpcr_pkg::OFS_DEN, 8'hFF);
		wr(B, gpcr_pkg::OFS_IEV, 8'h04);
		wr(B, gpcr_pkg::OFS_IMSK, 8'h04);
		cyc(6);
		wr(B, gpcr_pkg::OFS_ICLR, 8'hFF);
		irq_chk(1'b0);
		ext_val <= 8'h04;
		irq_chk(1'b1);
		rd(B, gpcr_pkg::OFS_RIS, 8'h04, 8'hFF);
		wr(B, gpcr_pkg::OFS_ICLR, 8'h04);
		irq_chk(1'b0);
		wr(B, gpcr_pkg::OFS_IEV, 8'h00);
		ext_val <= 8'h00;
		irq_chk(1'b1);
		wr(B, gpcr_pkg::OFS_ICLR, 8'h04);
		wr(B, gpcr_pkg::OFS_IBE, 8'h04);
		ext_val <= 8'h04;
		irq_chk(1'b1);
		wr(B, gpcr_pkg::OFS_ICLR, 8'h04);
		wr(B, gpcr_pkg::OFS_IEV, 8'h04);
		wr(B, gpcr_pkg::OFS_ISNS, 8'h04);
		wr(B, gpcr_pkg::OFS_ICLR, 8'h04);
		irq_chk(1'b1);
		wr(B, gpcr_pkg::OFS_IMSK, 8'h00);
		irq_chk(1'b0);
		wr(B, gpcr_pkg::OFS_IMSK, 8'h04);
		wr(B, gpcr_pkg::OFS_DEN, 8'hFB);
		wr(B, gpcr_pkg::OFS_ICLR, 8'h04);
		irq_chk(1'b0);
		end_of_test();
	end
endmodule : test_gpcr_port

// file: logic/gpcr_pkg.sv
// Shared constants and types for the GPIO port configuration block
package gpcr_pkg;

	// ****************************************
	// Register offsets within one port window
	// ****************************************
	localparam logic [11:0] OFS_DATA  = 12'h000;
	localparam logic [11:0] OFS_DIR   = 12'h400;
	localparam logic [11:0] OFS_ISNS  = 12'h404;
	localparam logic [11:0] OFS_IBE   = 12'h408;
	localparam logic [11:0] OFS_IEV   = 12'h40C;
	localparam logic [11:0] OFS_IMSK  = 12'h410;
	localparam logic [11:0] OFS_RIS   = 12'h414;
	localparam logic [11:0] OFS_ICLR  = 12'h41C;
	localparam logic [11:0] OFS_AFSEL = 12'h420;
	localparam logic [11:0] OFS_DRV2  = 12'h500;
	localparam logic [11:0] OFS_DRV4  = 12'h504;
	localparam logic [11:0] OFS_DRV8  = 12'h508;
	localparam logic [11:0] OFS_ODR   = 12'h50C;
	localparam logic [11:0] OFS_PUR   = 12'h510;
	localparam logic [11:0] OFS_PDR   = 12'h514;
	localparam logic [11:0] OFS_SLEW  = 12'h518;
	localparam logic [11:0] OFS_DEN   = 12'h51C;
	localparam logic [11:0] OFS_LOCK  = 12'h520;
	localparam logic [11:0] OFS_CMT   = 12'h524;

	// ****************************************
	// Base addresses and reset values
	// ****************************************
	localparam logic [31:0] BASE_LO   = 32'h4000_4000;
	localparam logic [31:0] BASE_HI   = 32'h4002_4000;
	localparam logic [2:0]  PORT_B    = 3'h1;
	localparam logic [2:0]  PORT_C    = 3'h2;
	localparam logic [7:0]  PROT_B    = 8'h80;
	localparam logic [7:0]  PROT_C    = 8'h0F;
	localparam logic [7:0]  CMT_RST   = 8'hFF;
	localparam logic [7:0]  ZERO8     = 8'h00;
	localparam logic [31:0] LOCK_KEY  = 32'h0000_C0DE;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} gpcr_bus_t;

	typedef struct packed {
		logic [7:0] open_drain_select;
		logic [7:0] pull_up_select;
		logic [7:0] pull_down_select;
		logic [7:0] drive_low_strength;
		logic [7:0] drive_mid_strength;
		logic [7:0] drive_high_strength;
		logic [7:0] slew_rate_control;
		logic [7:0] digital_enable_reg;
	} gpcr_pad_cfg_t;

	// Ports A-D and E-H sit in two windows 0x20000 apart; ports within a window sit one page apart
	function automatic logic [31:0] port_base(input logic [2:0] p);
		port_base = (p[2] ? BASE_HI : BASE_LO) | {18'h0, p[1:0], 12'h000};
	endfunction : port_base

	// Debug pins guarded by the commit mechanism
	function automatic logic [7:0] prot_mask(input logic [2:0] p);
		prot_mask = (p == PORT_B) ? PROT_B : (p == PORT_C) ? PROT_C : ZERO8;
	endfunction : prot_mask

endpackage : gpcr_pkg

// file: logic/gpcr_port.sv
// One eight-pin GPIO port: registers, pad control, commit guard
`timescale 1ns/1ps
module gpcr_port #(
	parameter logic [2:0] PORT_ID  = 3'h0,
	parameter logic [7:0] PAD_MASK = 8'hFF
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Register port
	input  wire gpcr_pkg::gpcr_bus_t    bus,
	output logic               [31:0]   bus_rdata,
	// Pads
	input  wire logic          [7:0]    pad_in,
	output logic               [7:0]    pad_out,
	output logic               [7:0]    pad_oe,
	output gpcr_pkg::gpcr_pad_cfg_t     pad_cfg,
	// Alternate-function peripherals
	input  wire logic          [7:0]    alt_out,
	input  wire logic          [7:0]    alt_oe,
	output logic               [7:0]    alt_in,
	// Port interrupt
	output logic                        port_irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]              port_data_reg;
		logic [7:0]              dir;
		logic [7:0]              alt_function_select;
		gpcr_pkg::gpcr_pad_cfg_t cfg;
		logic [7:0]              irq_sense_select;
		logic [7:0]              irq_both_edges;
		logic [7:0]              irq_event_polarity;
		logic [7:0]              irq_mask;
		logic [7:0]              raw_stat;
		logic [7:0]              commit_enable;
		logic                    unlocked;
		logic [31:0]             rdata;
		logic [7:0]              pout;
		logic [7:0]              poe;
		logic [7:0]              ain;
		logic                    irq;
	} gpcr_port_st_t;

	localparam logic [31:0] BASE = gpcr_pkg::port_base(PORT_ID);
	localparam logic [7:0]  PROT = gpcr_pkg::prot_mask(PORT_ID);

	gpcr_port_st_t q;
	gpcr_port_st_t d;
	logic [7:0]    sync_val;
	logic [7:0]    pin;
	logic [7:0]    trig_hit;
	logic          sel;
	logic [7:0]    wd;
	logic [7:0]    af_wmask;
	logic [7:0]    cmt_wmask;
	logic [7:0]    gpio_out;
	logic [7:0]    o_raw;
	logic [7:0]    oe_raw;
	logic [7:0]    clr;
	logic [7:0]    drv_gpio;
	logic [7:0]    drv_alt;

	// ****************************************
	// Pad input path
	// ****************************************
	gpcr_sync u_sync (
		.clk    (clk),
		.rst    (rst),
		.pad_in (pad_in),
		.val    (sync_val)
	);

	// Input blocked when the digital buffer is off
	assign pin = sync_val & q.cfg.digital_enable_reg & PAD_MASK;

	gpcr_trig u_trig (
		.clk                (clk),
		.rst                (rst),
		.val                (pin),
		.irq_sense_select   (q.irq_sense_select),
		.irq_both_edges     (q.irq_both_edges),
		.irq_event_polarity (q.irq_event_polarity),
		.hit                (trig_hit)
	);

	// ****************************************
	// Decode helpers
	// ****************************************
	assign sel = bus.addr[31:12] == BASE[31:12];
	assign wd  = bus.wdata[7:0];

	function automatic logic hit(input logic [11:0] o);
		hit = sel && (bus.addr[11:0] == o);
	endfunction : hit

	function automatic logic [7:0] merge(
		input logic [7:0] old,
		input logic [7:0] nw,
		input logic [7:0] m
	);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// Guarded pins only take AF writes when unlocked and committable
	assign af_wmask  = PAD_MASK & (~PROT | (q.commit_enable &
		{8{q.unlocked}}));
	assign cmt_wmask = PAD_MASK & PROT & {8{q.unlocked}};
	assign gpio_out  = q.dir & ~q.alt_function_select;
	// Decoded in place: a continuous assignment would not follow the
	// address that the decode function reads
	assign clr       = (bus.wr && sel &&
		bus.addr[11:0] == gpcr_pkg::OFS_ICLR) ? wd : gpcr_pkg::ZERO8;
	assign o_raw     = (q.alt_function_select & alt_out) |
		(~q.alt_function_select & q.port_data_reg);
	assign oe_raw    = (q.alt_function_select & alt_oe) |
		(~q.alt_function_select & q.dir);
	assign drv_gpio  = gpio_out & q.cfg.digital_enable_reg &
		~q.cfg.open_drain_select & PAD_MASK;
	assign drv_alt   = q.alt_function_select & q.cfg.digital_enable_reg &
		~q.cfg.open_drain_select & PAD_MASK;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		d       = q;
		d.rdata = '0;
		if (bus.wr)
		begin
			// Unconnected bits never store a write
			if (hit(gpcr_pkg::OFS_DATA))
				d.port_data_reg = merge(q.port_data_reg, wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_DIR))
				d.dir = merge(q.dir, wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_ISNS))
				d.irq_sense_select = merge(q.irq_sense_select, wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_IBE))
				d.irq_both_edges = merge(q.irq_both_edges, wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_IEV))
				d.irq_event_polarity = merge(q.irq_event_polarity, wd,
					PAD_MASK);
			if (hit(gpcr_pkg::OFS_IMSK))
				d.irq_mask = merge(q.irq_mask, wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_AFSEL))
				d.alt_function_select = merge(q.alt_function_select, wd,
					af_wmask);
			if (hit(gpcr_pkg::OFS_DRV2))
				d.cfg.drive_low_strength = merge(q.cfg.drive_low_strength,
					wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_DRV4))
				d.cfg.drive_mid_strength = merge(q.cfg.drive_mid_strength,
					wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_DRV8))
				d.cfg.drive_high_strength = merge(q.cfg.drive_high_strength,
					wd, PAD_MASK);
			if (hit(gpcr_pkg::OFS_ODR))
				d.cfg.open_drain_select = merge(q.cfg.open_drain_select, wd,
					PAD_MASK);
			if (hit(gpcr_pkg::OFS_PUR))
				d.cfg.pull_up_select = merge(q.cfg.pull_up_select, wd,
					PAD_MASK);
			if (hit(gpcr_pkg::OFS_PDR))
				d.cfg.pull_down_select = merge(q.cfg.pull_down_select, wd,
					PAD_MASK);
			if (hit(gpcr_pkg::OFS_SLEW))
				d.cfg.slew_rate_control = merge(q.cfg.slew_rate_control, wd,
					PAD_MASK);
			if (hit(gpcr_pkg::OFS_DEN))
				d.cfg.digital_enable_reg = merge(q.cfg.digital_enable_reg,
					wd, PAD_MASK);
			// Any other value relocks
			if (hit(gpcr_pkg::OFS_LOCK))
				d.unlocked = bus.wdata == gpcr_pkg::LOCK_KEY;
			if (hit(gpcr_pkg::OFS_CMT))
				d.commit_enable = merge(q.commit_enable, wd, cmt_wmask);
		end

		// New trigger wins over a clear in the same cycle
		d.raw_stat = ((q.raw_stat & ~clr) |
			(trig_hit & q.cfg.digital_enable_reg)) & PAD_MASK;
		d.irq = |(d.raw_stat & d.irq_mask);

		// Open drain only ever pulls low; push-pull follows the source
		d.pout = o_raw & ~q.cfg.open_drain_select;
		d.poe  = PAD_MASK & q.cfg.digital_enable_reg & oe_raw &
			~(q.cfg.open_drain_select & o_raw);
		d.ain  = pin & q.alt_function_select;

		if (bus.rd && sel)
		begin
			case (bus.addr[11:0])
				gpcr_pkg::OFS_DATA:
					d.rdata[7:0] = (q.port_data_reg & gpio_out) |
						(pin & ~gpio_out);
				gpcr_pkg::OFS_DIR:   d.rdata[7:0] = q.dir;
				gpcr_pkg::OFS_ISNS:  d.rdata[7:0] = q.irq_sense_select;
				gpcr_pkg::OFS_IBE:   d.rdata[7:0] = q.irq_both_edges;
				gpcr_pkg::OFS_IEV:   d.rdata[7:0] = q.irq_event_polarity;
				gpcr_pkg::OFS_IMSK:  d.rdata[7:0] = q.irq_mask;
				gpcr_pkg::OFS_RIS:   d.rdata[7:0] = q.raw_stat;
				gpcr_pkg::OFS_AFSEL: d.rdata[7:0] = q.alt_function_select;
				gpcr_pkg::OFS_DRV2:  d.rdata[7:0] = q.cfg.drive_low_strength;
				gpcr_pkg::OFS_DRV4:  d.rdata[7:0] = q.cfg.drive_mid_strength;
				gpcr_pkg::OFS_DRV8:  d.rdata[7:0] = q.cfg.drive_high_strength;
				gpcr_pkg::OFS_ODR:   d.rdata[7:0] = q.cfg.open_drain_select;
				gpcr_pkg::OFS_PUR:   d.rdata[7:0] = q.cfg.pull_up_select;
				gpcr_pkg::OFS_PDR:   d.rdata[7:0] = q.cfg.pull_down_select;
				gpcr_pkg::OFS_SLEW:  d.rdata[7:0] = q.cfg.slew_rate_control;
				gpcr_pkg::OFS_DEN:   d.rdata[7:0] = q.cfg.digital_enable_reg;
				gpcr_pkg::OFS_LOCK:  d.rdata[0]   = ~q.unlocked;
				gpcr_pkg::OFS_CMT:   d.rdata[7:0] = q.commit_enable;
				default:             d.rdata      = '0;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q                        <= '0;
			q.alt_function_select    <= PROT;
			q.cfg.pull_up_select     <= PROT;
			q.cfg.digital_enable_reg <= PROT;
			q.commit_enable          <= gpcr_pkg::CMT_RST & ~PROT;
		end
		else
			q <= d;
	end

	assign bus_rdata = q.rdata;
	assign pad_out   = q.pout;
	assign pad_oe    = q.poe;
	assign pad_cfg   = q.cfg;
	assign alt_in    = q.ain;
	assign port_irq  = q.irq;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_RST_UNDRIVEN: assert property ($fell(rst) |-> pad_oe == 8'h00 &&
		pad_cfg.pull_down_select == 8'h00 &&
		(pad_cfg.pull_up_select & ~PROT) == 8'h00)
		else $error("pads not undriven after reset");
	AST_UNCONN_WR: assert property (bus.wr |=> ((q.dir | q.port_data_reg) &
		~PAD_MASK) == 8'h00)
		else $error("unconnected bit stored a write");
	AST_RST_AF: assert property ($fell(rst) |-> q.alt_function_select ==
		PROT && pad_cfg.digital_enable_reg == PROT)
		else $error("alternate select reset value wrong");
	AST_CMT_RO: assert property (bus.wr && hit(gpcr_pkg::OFS_CMT) |=>
		(q.commit_enable & ~PROT) == ($past(q.commit_enable) & ~PROT))
		else $error("read-only commit bit changed");
	AST_RST_CMT: assert property ($fell(rst) |-> q.commit_enable ==
		(gpcr_pkg::CMT_RST & ~PROT))
		else $error("commit reset value wrong");
	AST_OD_LOW: assert property (1 |=> (pad_out & pad_oe &
		$past(q.cfg.open_drain_select)) == 8'h00)
		else $error("open drain pin driven high");
	AST_GPIO_DRV: assert property (1 |=> ((pad_out ^ $past(q.port_data_reg)) &
		$past(drv_gpio)) == 8'h00 && (~pad_oe & $past(drv_gpio)) == 8'h00)
		else $error("output pin does not follow data");
	AST_AF_LOCK: assert property (bus.wr && !q.unlocked |=>
		(q.alt_function_select & PROT) ==
		($past(q.alt_function_select) & PROT))
		else $error("guarded alternate bit changed while locked");
	AST_ALT_DRV: assert property (1 |=> ((pad_oe ^ $past(alt_oe)) &
		$past(drv_alt)) == 8'h00 && ((pad_out ^ $past(alt_out)) &
		$past(drv_alt)) == 8'h00)
		else $error("alternate pin does not follow peripheral");
	AST_DEN_IRQ: assert property (1 |=> (q.raw_stat & ~$past(q.raw_stat) &
		~$past(q.cfg.digital_enable_reg)) == 8'h00)
		else $error("disabled pin raised a trigger");
	AST_RD_OTHER: assert property (bus.rd && !sel |=>
		bus_rdata == 32'h0000_0000)
		else $error("read answered outside this port window");
	AST_UNCONN_CFG: assert property (((pad_cfg.pull_up_select |
		pad_cfg.pull_down_select | pad_cfg.open_drain_select |
		pad_cfg.digital_enable_reg) & ~PAD_MASK) == 8'h00)
		else $error("unconnected pad bit configured");
	AST_DATA_OUT: assert property (bus.rd &&
		hit(gpcr_pkg::OFS_DATA) |=> ((bus_rdata[7:0] ^
		$past(q.port_data_reg)) & $past(gpio_out)) == 8'h00)
		else $error("output pin read does not return stored data");
	AST_DEN_IN: assert property (bus.rd &&
		hit(gpcr_pkg::OFS_DATA) |=> (bus_rdata[7:0] & ~$past(gpio_out) &
		~$past(q.cfg.digital_enable_reg)) == 8'h00)
		else $error("disabled input pin read as one");
	AST_AF_IN: assert property (1 |=> (alt_in &
		~$past(q.alt_function_select)) == 8'h00)
		else $error("peripheral saw a pin it does not own");
	AST_IRQ_MASK: assert property (port_irq ==
		|(q.raw_stat & q.irq_mask))
		else $error("port interrupt disagrees with masked status");

	// ****************************************
	// Cover points
	// ****************************************
	COV_UNLOCK: cover property (bus.wr && hit(gpcr_pkg::OFS_LOCK) ##1
		q.unlocked);
	COV_LEVEL_IRQ: cover property (port_irq &&
		|(q.irq_sense_select & q.irq_mask));
	COV_OD_AF: cover property (|(q.alt_function_select &
		q.cfg.open_drain_select & q.cfg.digital_enable_reg));
	COV_AF_COMMIT: cover property (q.unlocked && bus.wr &&
		hit(gpcr_pkg::OFS_AFSEL) ##1 $changed(q.alt_function_select));
	COV_IRQ: cover property ($rose(port_irq));
endmodule : gpcr_port

// file: logic/gpcr_sync.sv
// Three-stage pad input synchroniser with agreement filter
`timescale 1ns/1ps
module gpcr_sync (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Pads and filtered value
	input  wire logic [7:0] pad_in,
	output logic      [7:0] val
);
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] v;
	} gpcr_sync_st_t;

	gpcr_sync_st_t q;
	gpcr_sync_st_t d;

	// A bit changes only once stages two and three agree
	always_comb
	begin
		d    = q;
		d.s1 = pad_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.v  = (q.v & (q.s2 ^ q.s3)) | (q.s2 & ~(q.s2 ^ q.s3));
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	assign val = q.v;
endmodule : gpcr_sync

// file: logic/gpcr_trig.sv
// Per-pin interrupt trigger detection: edge or level, polarity
`timescale 1ns/1ps
module gpcr_trig (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Gated pin value and trigger setup
	input  wire logic [7:0] val,
	input  wire logic [7:0] irq_sense_select,
	input  wire logic [7:0] irq_both_edges,
	input  wire logic [7:0] irq_event_polarity,
	// Trigger seen this cycle
	output logic      [7:0] hit
);
	typedef struct packed {
		logic [7:0] prev;
	} gpcr_trig_st_t;

	gpcr_trig_st_t q;
	gpcr_trig_st_t d;

	always_comb
	begin
		d      = q;
		d.prev = val;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	for (genvar i = 0; i < 8; i++)
	begin : g_pin
		logic rise;
		logic fall;
		assign rise = val[i] & ~q.prev[i];
		assign fall = ~val[i] & q.prev[i];
		// Level when sense is 1, else edge; polarity unless both edges
		assign hit[i] = irq_sense_select[i]
			? (irq_event_polarity[i] ? val[i] : ~val[i])
			: (irq_both_edges[i] ? (rise | fall)
			: (irq_event_polarity[i] ? rise : fall));
	end
endmodule : gpcr_trig
